/* mbm_params.svh */
// mbm_params.svh: register offsets, field positions and reset values
// of the memory based multiplier.
// assumes: included by bare name from the top module, the checker and the bench.
`ifndef MBM_PARAMS_SVH
`define MBM_PARAMS_SVH

// ==========================================================================
// register map (byte addresses on a 32-bit classic bus)
`define MBM_ADR_W        8
`define MBM_CTRL_OFS     8'h00
`define MBM_STAT_OFS     8'h04

// ==========================================================================
// control fields and reset value
`define MBM_CTRL_DSIGN   0
`define MBM_CTRL_CSIGN   1
`define MBM_CTRL_RST     2'h0

// ==========================================================================
// status fields
`define MBM_STAT_DONE    0
`define MBM_STAT_GOOD    1
`define MBM_STAT_BUSY    2
`define MBM_STAT_FILL    3

// ==========================================================================
// configuration defaults
`define MBM_MULT_W       8
`define MBM_COEF_W       8
`define MBM_CHOICE_W     1
`define MBM_CYCLES       2
`define MBM_INIT_COEF    0

`endif

/* mbm_pkg.sv */
// mbm_pkg.sv: types shared by the memory based multiplier files.
// assumes: mbm_params.svh holds the register map and defaults; this file holds types and the loader state encodings.
package mbm_pkg;

  // ========================================================================
  // loader state, one-hot
  typedef enum logic [1:0] {
    MBM_LD_IDLE = 2'b01,
    MBM_LD_FILL = 2'b10
  } mbm_ld_e;

  // ========================================================================
  // software control and visible status
  typedef struct packed {
    logic coef_signed;
    logic data_signed;
  } mbm_ctrl_s;

  typedef struct packed {
    logic filling;
    logic busy;
    logic good;
    logic finished;
  } mbm_stat_s;

endpackage : mbm_pkg

/* mbm_lut.sv */
// mbm_lut.sv: partial product table, one write port, one read port.
// assumes: a single clock; the read is combinational so that a digit can
// be looked up and accumulated in the same cycle.
`timescale 1ns/1ps
module mbm_lut #(
  parameter int AW = 5,
  parameter int DW = 13
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);

  // ========================================================================
  // storage; no reset, contents are built by the loader after reset
  logic [DW-1:0] mem [0:(2**AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule : mbm_lut

/* mbm_mult.sv */
// mbm_mult.sv: multiplier built from table lookups with a Wishbone
// control and status port.
// assumes: all user inputs come from logic on clk_i; Wishbone classic
// master on the same clock.
`timescale 1ns/1ps
`include "mbm_params.svh"

// Notes on behaviour
// - products come from memory tables, no multiplier
// - everything runs on the single clock
// - coefficient bus is coef_bus_width wide
// - multiplicand bus is multiplicand_width wide
// - optional synchronous clear, active high
// - coef_choice picks the stored coefficient
// - load writes coefficient input into selected slot
// - begin restarts multiplication, abandons current one
// - begin ignored when one cycle per product
// - product bus is product_width wide
// - good only while product is complete result
// - finished flag rises after table fully rewritten
// - multiplicand width from allowed set, signed option
// - coefficient up to 24 bits, signed option
// - load and clear ports always exist; their inputs are ignored unless enabled
module mbm_mult #(
  parameter int MULT_W   = `MBM_MULT_W,
  parameter int COEF_W   = `MBM_COEF_W,
  parameter int CHOICE_W = `MBM_CHOICE_W,
  parameter int PROD_W   = `MBM_MULT_W + `MBM_COEF_W,
  parameter int CYCLES   = `MBM_CYCLES,
  parameter int INIT_COEF = `MBM_INIT_COEF,
  parameter bit HAS_LOAD = 1'b1,
  parameter bit HAS_SCLR = 1'b1
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`MBM_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [MULT_W-1:0]     multiplicand_i,
  input  wire logic [CHOICE_W-1:0]   coef_choice_i,
  input  wire logic [COEF_W-1:0]     coef_i,
  input  wire logic                  write_new_coef_i,
  input  wire logic                  begin_new_product_i,
  input  wire logic                  sync_clear_i,
  output logic      [PROD_W-1:0]     product_o,
  output logic                       product_good_o,
  output logic                       coef_write_finished_o
);
  import mbm_pkg::*;

  // ========================================================================
  // derived sizes
  localparam int DIG_W = (MULT_W + CYCLES - 1) / CYCLES;
  localparam int XW    = CYCLES * DIG_W;          // padded multiplicand
  localparam int EW    = COEF_W + DIG_W + 1;      // table entry, signed
  localparam int FW    = XW + COEF_W + 2;         // accumulator, signed
  localparam int AW    = CHOICE_W + DIG_W;
  localparam int CW_CNT = $clog2(CYCLES + 1);
  localparam logic [DIG_W-1:0]    DIG_LAST = {DIG_W{1'b1}};
  localparam logic [CHOICE_W-1:0] SEL_LAST = {CHOICE_W{1'b1}};

  // ========================================================================
  // elaboration checks
  generate
    if (!(MULT_W inside {2, 3, 4, 5, 6, 7, 8, 16, 24, 32}))
    begin : g_bad_mult_w
      $error("multiplicand width not supported");
    end
    if (COEF_W < 2 || COEF_W > 24)
    begin : g_bad_coef_w
      $error("coefficient width must be 2 to 24");
    end
    if (CYCLES < 1 || CYCLES > MULT_W || PROD_W < 1 ||
        PROD_W > MULT_W + COEF_W || CHOICE_W < 1)
    begin : g_bad_shape
      $error("cycle count or widths out of range");
    end
    if (INIT_COEF < 0 || INIT_COEF > 4 || INIT_COEF >= 2**(COEF_W-1))
    begin : g_bad_init
      $error("initial coefficient must be 0 to 4 and fit");
    end
  endgenerate

  // ========================================================================
  // helpers
  function automatic logic [EW-1:0] ext_coef(input logic [COEF_W-1:0] c,
                                             input logic sgn);
    ext_coef = sgn ? {{(EW-COEF_W){c[COEF_W-1]}}, c}
                   : {{(EW-COEF_W){1'b0}}, c};
  endfunction : ext_coef

  function automatic logic [XW-1:0] ext_data(input logic [MULT_W-1:0] d,
                                             input logic sgn);
    if (XW == MULT_W)
      ext_data = d;
    else
      ext_data = sgn ? {{(XW-MULT_W+1){d[MULT_W-1]}}, d[MULT_W-2:0]}
                     : {{(XW-MULT_W+1){1'b0}}, d[MULT_W-2:0]} |
                       {{(XW-MULT_W){1'b0}}, d[MULT_W-1], {(MULT_W-1){1'b0}}};
  endfunction : ext_data

  // ========================================================================
  // register bus
  mbm_ctrl_s   ctrl;
  mbm_ctrl_s   next_ctrl;
  mbm_stat_s   stat;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        bus_req;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb
  begin
    next_ctrl = ctrl;
    next_dat  = 32'h0000_0000;
    next_ack  = bus_req;
    if (bus_req)
    begin
      case (wb_adr_i)
        `MBM_CTRL_OFS:
        begin
          if (wb_we_i && wb_sel_i[0])
            next_ctrl = mbm_ctrl_s'(wb_dat_i[1:0]);
          next_dat = {30'h0, ctrl};
        end
        `MBM_STAT_OFS: next_dat = {28'h0, stat};
        default:       next_dat = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl     <= mbm_ctrl_s'(`MBM_CTRL_RST);
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      ctrl     <= next_ctrl;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

  // ========================================================================
  // coefficient loader: builds c*d for every digit value by addition
  mbm_ld_e             ld_state;
  mbm_ld_e             next_ld_state;
  logic [CHOICE_W-1:0] ld_sel;
  logic [CHOICE_W-1:0] next_ld_sel;
  logic [DIG_W-1:0]    ld_dig;
  logic [DIG_W-1:0]    next_ld_dig;
  logic [EW-1:0]       ld_acc;
  logic [EW-1:0]       next_ld_acc;
  logic [COEF_W-1:0]   ld_coef;
  logic [COEF_W-1:0]   next_ld_coef;
  logic                ld_sweep;
  logic                next_ld_sweep;
  logic                next_finished;
  logic                lut_we;
  logic                load_req;

  assign lut_we   = (ld_state == MBM_LD_FILL);
  // loads only accepted while finished is high
  assign load_req = HAS_LOAD && write_new_coef_i && coef_write_finished_o;

  always_comb
  begin
    next_ld_state = ld_state;
    next_ld_sel   = ld_sel;
    next_ld_dig   = ld_dig;
    next_ld_acc   = ld_acc;
    next_ld_coef  = ld_coef;
    next_ld_sweep = ld_sweep;
    next_finished = coef_write_finished_o;
    case (ld_state)
      MBM_LD_IDLE:
      begin
        if (load_req)
        begin
          next_ld_state = MBM_LD_FILL;
          next_ld_sel   = coef_choice_i;
          next_ld_coef  = coef_i;
          next_ld_dig   = '0;
          next_ld_acc   = '0;
          next_finished = 1'b0;
        end
      end
      MBM_LD_FILL:
      begin
        next_ld_acc = ld_acc + ext_coef(ld_coef, ctrl.coef_signed);
        next_ld_dig = ld_dig + 1'b1;
        if (ld_dig == DIG_LAST)
        begin
          next_ld_acc = '0;
          if (ld_sweep && ld_sel != SEL_LAST)
            next_ld_sel = ld_sel + 1'b1;
          else
          begin
            next_ld_state = MBM_LD_IDLE;
            next_ld_sweep = 1'b0;
            next_finished = 1'b1;
          end
        end
      end
      default:
      begin
        next_ld_state = MBM_LD_IDLE;
        next_finished = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // every slot is filled with the initial coefficient after reset
      ld_state              <= MBM_LD_FILL;
      ld_sel                <= '0;
      ld_dig                <= '0;
      ld_acc                <= '0;
      ld_coef               <= COEF_W'(INIT_COEF);
      ld_sweep              <= 1'b1;
      coef_write_finished_o <= 1'b0;
    end
    else
    begin
      ld_state              <= next_ld_state;
      ld_sel                <= next_ld_sel;
      ld_dig                <= next_ld_dig;
      ld_acc                <= next_ld_acc;
      ld_coef               <= next_ld_coef;
      ld_sweep              <= next_ld_sweep;
      coef_write_finished_o <= next_finished;
    end
  end

  // raw coefficients kept for the sign fix of the top digit
  logic [COEF_W-1:0] coef_mem [0:(2**CHOICE_W)-1];

  always_ff @(posedge clk_i)
  begin
    if (lut_we && ld_dig == '0)
    begin
      coef_mem[ld_sel] <= ld_coef;
    end
  end

  // ========================================================================
  // table lookup
  logic                run;
  logic [CHOICE_W-1:0] sel_q;
  logic [XW-1:0]       data_q;
  logic                first;
  logic [CHOICE_W-1:0] sel_use;
  logic [XW-1:0]       dsrc;
  logic [DIG_W-1:0]    digit;
  logic [EW-1:0]       lut_rd;
  logic [FW-1:0]       part;

  // one cycle per product: every cycle is a fresh lookup
  // a begin during a run must look up the new operand, not the held one
  assign first   = (CYCLES == 1) || !run || begin_new_product_i;
  assign sel_use = first ? coef_choice_i : sel_q;
  assign dsrc    = first ? ext_data(multiplicand_i, ctrl.data_signed)
                         : data_q;
  assign digit   = dsrc[XW-1 -: DIG_W];

  mbm_lut #(
    .AW (AW),
    .DW (EW)
  ) u_lut (
    .clk_i   (clk_i),
    .we_i    (lut_we),
    .waddr_i ({ld_sel, ld_dig}),
    .wdata_i (ld_acc),
    .raddr_i ({sel_use, digit}),
    .rdata_o (lut_rd)
  );

  // top digit of signed data weighs negative: subtract c << DIG_W
  always_comb
  begin
    part = {{(FW-EW){lut_rd[EW-1]}}, lut_rd};
    if (first && ctrl.data_signed && digit[DIG_W-1])
      part = part - (FW'({{(FW-EW){1'b0}},
             ext_coef(coef_mem[sel_use], ctrl.coef_signed)}) << DIG_W);
  end

  // ========================================================================
  // digit serial accumulation, most significant digit first
  logic [FW-1:0]       acc;
  logic [FW-1:0]       next_acc;
  logic [FW-1:0]       sum;
  logic                next_run;
  logic [CHOICE_W-1:0] next_sel_q;
  logic [XW-1:0]       next_data_q;
  logic [CW_CNT-1:0]   cnt;
  logic [CW_CNT-1:0]   next_cnt;
  logic [PROD_W-1:0]   next_product;
  logic                next_good;
  logic                clear;

  assign clear = HAS_SCLR && sync_clear_i;
  assign sum   = (acc << DIG_W) + part;

  always_comb
  begin
    next_acc     = acc;
    next_run     = run;
    next_sel_q   = sel_q;
    next_data_q  = data_q;
    next_cnt     = cnt;
    next_product = product_o;
    next_good    = product_good_o;
    if (clear)
    begin
      next_acc     = '0;
      next_run     = 1'b0;
      next_cnt     = '0;
      next_product = '0;
      next_good    = 1'b0;
    end
    else if (CYCLES == 1)
    begin
      next_product = part[PROD_W-1:0];
      next_good    = 1'b0;
    end
    else if (begin_new_product_i)
    begin
      // restart discards any partial sum
      next_acc    = part;
      next_run    = 1'b1;
      next_sel_q  = coef_choice_i;
      next_data_q = dsrc << DIG_W;
      next_cnt    = CW_CNT'(CYCLES - 1);
      next_good   = 1'b0;
    end
    else if (run)
    begin
      next_data_q = data_q << DIG_W;
      next_cnt    = cnt - 1'b1;
      next_acc    = sum;
      if (cnt == CW_CNT'(1))
      begin
        next_run     = 1'b0;
        next_product = sum[PROD_W-1:0];
        next_good    = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc            <= '0;
      run            <= 1'b0;
      sel_q          <= '0;
      data_q         <= '0;
      cnt            <= '0;
      product_o      <= '0;
      product_good_o <= 1'b0;
    end
    else
    begin
      acc            <= next_acc;
      run            <= next_run;
      sel_q          <= next_sel_q;
      data_q         <= next_data_q;
      cnt            <= next_cnt;
      product_o      <= next_product;
      product_good_o <= next_good;
    end
  end

  // status seen by software
  assign stat = '{filling:  lut_we,
                  busy:     run,
                  good:     product_good_o,
                  finished: coef_write_finished_o};

endmodule : mbm_mult

/* mbm_mult_sva.sv */
// mbm_mult_sva.sv: port-level checks of the lookup multiplier.
// assumes: bound into mbm_mult; one clock, synchronous reset rst_i.
`timescale 1ns/1ps
`include "mbm_params.svh"
module mbm_mult_sva #(
  parameter int MULT_W = 8,
  parameter int CYCLES = 2,
  parameter int PROD_W = 16
) (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic [`MBM_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0]           wb_dat_o,
  input wire logic                  wb_ack_o,
  input wire logic                  begin_new_product_i,
  input wire logic                  write_new_coef_i,
  input wire logic                  sync_clear_i,
  input wire logic [PROD_W-1:0]     product_o,
  input wire logic                  product_good_o,
  input wire logic                  coef_write_finished_o
);
  // fill length of one slot; good timing assumes CYCLES of 2
  localparam int FILL_M1 = 2 ** ((MULT_W + CYCLES - 1) / CYCLES) - 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // sequences
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_run;
    begin_new_product_i && !sync_clear_i
      ##1 !begin_new_product_i && !sync_clear_i;
  endsequence
  sequence s_load;
    write_new_coef_i && coef_write_finished_o;
  endsequence
  // ==========
  // assertions
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (s_take |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_unmapped_zero: assert property (s_take ##0 (!wb_we_i
    && wb_adr_i != `MBM_CTRL_OFS && wb_adr_i != `MBM_STAT_OFS)
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_run_drops_good: assert property (begin_new_product_i
    |=> !product_good_o)
    else $error("good kept across a new start");
  a_run_gives_good: assert property (s_run |=> product_good_o)
    else $error("good missing after a run");
  a_good_stands: assert property (product_good_o
    && !begin_new_product_i && !sync_clear_i
    |=> product_good_o && $stable(product_o))
    else $error("completed result did not stand");
  a_clear_zeroes: assert property (sync_clear_i
    |=> product_o == '0 && !product_good_o)
    else $error("clear did not zero the result");
  a_fill_length: assert property (s_load |=> !coef_write_finished_o
    ##FILL_M1 !coef_write_finished_o ##1 coef_write_finished_o)
    else $error("coefficient fill length wrong");
endmodule : mbm_mult_sva

bind mbm_mult mbm_mult_sva #(.MULT_W(MULT_W), .CYCLES(CYCLES),
  .PROD_W(PROD_W)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .begin_new_product_i(begin_new_product_i),
  .write_new_coef_i(write_new_coef_i), .sync_clear_i(sync_clear_i),
  .product_o(product_o), .product_good_o(product_good_o),
  .coef_write_finished_o(coef_write_finished_o));

/* mbm_user.sv */
// mbm_user.sv: model of the user logic that feeds the multiplier.
// assumes: tasks are entered in the time step of a rising clk_i edge.
`timescale 1ns/1ps
module mbm_user #(
  parameter int MULT_W   = 8,
  parameter int COEF_W   = 8,
  parameter int CHOICE_W = 1
) (
  input  wire logic                clk_i,
  input  wire logic                finished_i,
  output logic      [MULT_W-1:0]   multiplicand_o,
  output logic      [CHOICE_W-1:0] coef_choice_o,
  output logic      [COEF_W-1:0]   coef_o,
  output logic                     write_new_coef_o,
  output logic                     begin_new_product_o,
  output logic                     sync_clear_o
);
  initial
  begin
    multiplicand_o = '0;
    coef_choice_o = '0;
    coef_o = '0;
    write_new_coef_o = 1'b0;
    begin_new_product_o = 1'b0;
    sync_clear_o = 1'b0;
  end
  // ==========
  // load; early set means a load the device must refuse
  task automatic load(input logic [CHOICE_W-1:0] ch,
                      input logic [COEF_W-1:0] c, input bit early);
    while (!early && finished_i !== 1'b1) @(posedge clk_i);
    write_new_coef_o <= 1'b1;
    coef_o <= c;
    coef_choice_o <= ch;
    @(posedge clk_i);
    write_new_coef_o <= 1'b0;
    // released lines never show a stale value
    coef_o <= ~c;
    coef_choice_o <= ~ch;
    // let finished fall before the next request looks at it
    @(posedge clk_i);
  endtask : load
  // ==========
  // start; twice restarts with b at the next edge
  task automatic start(input logic [MULT_W-1:0] a,
                       input logic [MULT_W-1:0] b,
                       input logic [CHOICE_W-1:0] ch, input bit twice);
    begin_new_product_o <= 1'b1;
    multiplicand_o <= a;
    coef_choice_o <= ch;
    @(posedge clk_i);
    if (twice)
    begin
      multiplicand_o <= b;
      @(posedge clk_i);
    end
    begin_new_product_o <= 1'b0;
    multiplicand_o <= twice ? ~b : ~a;
    coef_choice_o <= ~ch;
  endtask : start
  task automatic clear();
    sync_clear_o <= 1'b1;
    @(posedge clk_i);
    sync_clear_o <= 1'b0;
  endtask : clear
endmodule : mbm_user

/* mbm_mult_tb.sv */
// mbm_mult_tb.sv: self-checking bench for the lookup multiplier.
// assumes: default widths, two cycles a product, 100 MHz clock.
`timescale 1ns/1ps
`include "mbm_params.svh"
module mbm_mult_tb;
  import mbm_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel_b;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  mul;
  logic [0:0]  sel;
  logic [7:0]  coef;
  logic        wr_coef;
  logic        go;
  logic        clr;
  logic [15:0] prod_o;
  logic        good;
  logic        fin;
  int          n_errors;
  int          checked;
  int          cyc_cnt;
  int          coef_m [2];
  bit          sgn;
  mbm_stat_s   stat;

  mbm_mult #(.MULT_W(8), .COEF_W(8), .CHOICE_W(1), .PROD_W(16),
    .CYCLES(2)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel_b), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .multiplicand_i(mul),
    .coef_choice_i(sel), .coef_i(coef), .write_new_coef_i(wr_coef),
    .begin_new_product_i(go), .sync_clear_i(clr), .product_o(prod_o),
    .product_good_o(good), .coef_write_finished_o(fin));
  mbm_user u_user (
    .clk_i(clk_i), .finished_i(fin), .multiplicand_o(mul),
    .coef_choice_o(sel), .coef_o(coef), .write_new_coef_o(wr_coef),
    .begin_new_product_o(go), .sync_clear_o(clr));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt > 3000)
    begin
      n_errors++;
      close_out();
    end
  end
  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  function automatic logic [15:0] ref_prod(input logic [7:0] a, int c);
    int x;
    x = sgn ? int'($signed(a)) : int'(a);
    return 16'(x * c);
  endfunction : ref_prod
  task automatic load(input logic [0:0] s, input logic [7:0] c);
    u_user.load(s, c, 1'b0);
    coef_m[s] = sgn ? int'($signed(c)) : int'(c);
  endtask : load
  task automatic prod(input logic [7:0] a, input logic [7:0] b,
                      input logic [0:0] s, input bit twice);
    u_user.start(a, b, s, twice);
    repeat (2) @(posedge clk_i);
    #1;
    chk("product", 32'(prod_o), 32'(ref_prod(twice ? b : a, coef_m[s])));
    chk("good", 32'(good), 32'h1);
    @(posedge clk_i);
  endtask : prod
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ==========
  // main sequence
  initial
  begin
    logic [31:0] r;
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel_b = 4'hF;
    wdat = '0;
    n_errors = 0;
    checked = 0;
    cyc_cnt = 0;
    coef_m = '{0, 0};
    r = $urandom(53);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("fin_rst", 32'(fin), 32'h0);
    while (fin !== 1'b1) @(posedge clk_i);
    wb(1'b0, `MBM_STAT_OFS, 32'h0, r);
    stat = mbm_stat_s'(r[3:0]);
    chk("stat_fin", 32'(stat.finished), 32'h1);
    chk("stat_idle", 32'(r[3:1]), 32'h0);
    wb(1'b0, `MBM_CTRL_OFS, 32'h0, r);
    chk("ctrl_rst", r, 32'(`MBM_CTRL_RST));
    wb(1'b1, 8'h10, 32'hFF, r);
    wb(1'b0, 8'h10, 32'h0, r);
    chk("unmapped", r, 32'h0);
    prod(8'($urandom()), 8'h0, 1'b0, 1'b0);
    $display("registers and initial coefficient done");
    load(1'b0, 8'($urandom()));
    load(1'b1, 8'($urandom()));
    @(posedge clk_i);
    u_user.load(1'b1, 8'h5A, 1'b1);
    while (fin !== 1'b1) @(posedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat ($urandom_range(0, 3)) @(posedge clk_i);
      prod(8'($urandom()), 8'h0, 1'($urandom()), 1'b0);
    end
    prod(8'($urandom()), 8'($urandom()), 1'b1, 1'b1);
    $display("loads and products done");
    u_user.start(8'hFF, 8'h0, 1'b1, 1'b0);
    u_user.clear();
    @(posedge clk_i);
    #1;
    chk("clr_prod", 32'(prod_o), 32'h0);
    chk("clr_good", 32'(good), 32'h0);
    @(posedge clk_i);
    $display("clear done");
    wb(1'b1, `MBM_CTRL_OFS, 32'h3, r);
    wb(1'b0, `MBM_CTRL_OFS, 32'h0, r);
    chk("ctrl_wr", r, 32'h3);
    sgn = 1'b1;
    load(1'b0, 8'h80 | 8'($urandom()));
    load(1'b1, 8'($urandom()));
    while (fin !== 1'b1) @(posedge clk_i);
    for (int i = 0; i < 6; i++)
      prod(8'($urandom()), 8'h0, 1'(i), 1'b0);
    $display("signed products done");
    close_out();
  end
endmodule : mbm_mult_tb
